// ===== src/ugr_top.sv
// Summary of operation
// - Frame index, bits 10:0, loads host frame number at SOF end; read-only.
// - SOF ended with an error sets frame corrupt flag, bit 16.
// - SOF ended cleanly sets frame good flag, bit 17.
// - Both frame flags clear when a new SOF identifier arrives.
// - Start-of-frame event is raised at the identifier, not at packet end.
// - Global state bit 0 reads 1 in address state, else 0.
// - Writing 1 enters address state; writing 0 does nothing; only reset leaves.
// - Configured bit 1 reads state; write 1 configures, write 0 unconfigures.
// - Function address is seven bits, 6:0, zero after hardware reset; an end of bus reset keeps it.
// - Function enable bit 8 reads back; zero disables endpoints; one permits traffic.
// - Enable register ones set mask bits: endpoints 0-5, 8, 9, 11, 13.
// - Disable register ones clear mask bits with the same layout.
// - Mask register reads one for each enabled source, zero otherwise.
// - Mask bit 12 for end of bus reset always reads one.
// - Each end of bus reset restores the mask and resets endpoint control.
//
// Decided for this implementation: the register offsets and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "ugr_regs.svh"
module ugr_top import ugr_pkg::*; #(
  parameter int EP_COUNT = `UGR_EP_MAX
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire ugr_sof_in_t sof_in,
  input wire logic bus_reset_end,
  input wire logic [`UGR_MASK_W-1:0] irq_status,
  output logic frame_start_irq,
  output logic ep_csr_reset,
  output logic address_state_flag,
  output logic configured_flag,
  output logic [`UGR_FADDR_W-1:0] function_address_value,
  output logic function_enable_bit,
  output logic [`UGR_MASK_W-1:0] irq_mask_view,
  output logic device_irq
);
  // Endpoints beyond the implemented count keep their mask bits at zero.
  localparam logic [`UGR_EP_MAX-1:0] EP_BITS = `UGR_EP_MAX'((1 << EP_COUNT) - 1);
  localparam logic [`UGR_MASK_W-1:0] WR_MASK = `UGR_MASK_WRITABLE &
    {{(`UGR_MASK_W-`UGR_EP_MAX){1'b1}}, EP_BITS};

  // The mask layout has room for at most six endpoints.
  generate
    if (EP_COUNT < 1 || EP_COUNT > `UGR_EP_MAX) begin : g_bad_ep
      $error("EP_COUNT must lie between 1 and 6.");
    end
  endgenerate

  ugr_bus_req_t req;
  ugr_frame_t frame;
  ugr_core_state_t state_r;
  ugr_core_state_t state_nxt;
  ugr_sel_t sel;
  logic [31:0] rd_word;
  logic [`UGR_MASK_W-1:0] mask_view;
  logic [`UGR_MASK_W-1:0] irq_hit;
  logic [`UGR_MASK_W-1:0] wr_bits;

  // Maps a byte address to a register; misaligned and unused addresses hit nothing.
  function automatic ugr_sel_t reg_decode(input logic [`UGR_ADDR_W-1:0] addr);
    ugr_sel_t s;
    s = SEL_NONE;
    case (addr)
      `UGR_OFF_FRAME: s = SEL_FRAME;
      `UGR_OFF_GLB: s = SEL_GLB;
      `UGR_OFF_FADDR: s = SEL_FADDR;
      `UGR_OFF_IEN: s = SEL_IEN;
      `UGR_OFF_IDIS: s = SEL_IDIS;
      `UGR_OFF_IMASK: s = SEL_IMASK;
      default: s = SEL_NONE;
    endcase
    return s;
  endfunction : reg_decode

  // The bus front end adds one wait state to reads and none to writes.
  ugr_ahb_slave u_slave (
    .clk(clk),
    .rst_b(rst_b),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .rd_word(rd_word),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .req(req)
  );

  // Frame number and frame health capture.
  ugr_sof_capture u_sof (
    .clk(clk),
    .rst_b(rst_b),
    .sof_in(sof_in),
    .frame(frame)
  );

  // The end-of-bus-reset bit is forced on so that event can never be hidden.
  assign sel = reg_decode(req.addr);
  assign mask_view = state_r.mask | `UGR_MASK_FIXED;
  assign wr_bits = req.wdata[`UGR_MASK_W-1:0] & WR_MASK;

  // Each source is gated by its own mask bit.
  generate
    for (genvar i = 0; i < `UGR_MASK_W; i++) begin : g_irq_gate
      assign irq_hit[i] = irq_status[i] & mask_view[i];
    end
  endgenerate

  // Read multiplexer; write-only and unmapped words read as zero.
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (sel)
      SEL_FRAME: begin
        rd_word[`UGR_FRM_IDX_W-1:0] = frame.index;
        rd_word[`UGR_FRM_CORRUPT_BIT] = frame.corrupt;
        rd_word[`UGR_FRM_GOOD_BIT] = frame.good;
      end
      SEL_GLB: begin
        rd_word[`UGR_GLB_ADDR_BIT] = state_r.addr_state;
        rd_word[`UGR_GLB_CONF_BIT] = state_r.configured;
      end
      SEL_FADDR: begin
        rd_word[`UGR_FADDR_W-1:0] = state_r.fn_addr;
        rd_word[`UGR_FEN_BIT] = state_r.fn_en;
      end
      SEL_IMASK: begin
        rd_word[`UGR_MASK_W-1:0] = mask_view;
      end
      SEL_NONE, SEL_IEN, SEL_IDIS: begin
        rd_word = 32'h0000_0000;
      end
    endcase
  end

  // Register writes, then the end of bus reset, which overrides a same-cycle write to the
  // global state or mask because it stands for a fresh start of the device.
  always_comb begin
    state_nxt = state_r;
    state_nxt.csr_reset = 1'b0;
    state_nxt.irq = |irq_hit;
    if (req.wr) begin
      unique case (sel)
        SEL_GLB: begin
          // A zero leaves address state alone.
          state_nxt.addr_state = state_r.addr_state | req.wdata[`UGR_GLB_ADDR_BIT];
          state_nxt.configured = req.wdata[`UGR_GLB_CONF_BIT];
        end
        SEL_FADDR: begin
          state_nxt.fn_addr = req.wdata[`UGR_FADDR_W-1:0];
          state_nxt.fn_en = req.wdata[`UGR_FEN_BIT];
        end
        SEL_IEN: begin
          state_nxt.mask = state_r.mask | wr_bits;
        end
        SEL_IDIS: begin
          state_nxt.mask = state_r.mask & ~wr_bits;
        end
        SEL_NONE, SEL_FRAME, SEL_IMASK: begin
          state_nxt.mask = state_r.mask;
        end
      endcase
    end
    if (bus_reset_end) begin
      state_nxt.mask = `UGR_MASK_RST;
      state_nxt.csr_reset = 1'b1;
      state_nxt.addr_state = 1'b0;
      state_nxt.configured = 1'b0;
    end
  end

  // Control state, with the address and enable at their power-up values.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r.addr_state <= 1'b0;
      state_r.configured <= 1'b0;
      state_r.fn_addr <= `UGR_FADDR_RST;
      state_r.fn_en <= `UGR_FEN_RST;
      state_r.mask <= `UGR_MASK_RST;
      state_r.csr_reset <= 1'b0;
      state_r.irq <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Outputs all come from flip-flops; the interrupt lags its cause by one cycle.
  assign frame_start_irq = frame.start_evt;
  assign ep_csr_reset = state_r.csr_reset;
  assign address_state_flag = state_r.addr_state;
  assign configured_flag = state_r.configured;
  assign function_address_value = state_r.fn_addr;
  assign function_enable_bit = state_r.fn_en;
  assign irq_mask_view = mask_view;
  assign device_irq = state_r.irq;

  // Checks on the register and frame behaviour.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  chk_frame_load:
  assert property (sof_in.eop |=> frame.index == $past(sof_in.num))
    else $error("Frame index did not load at end of packet.");

  chk_frame_hold:
  assert property (!sof_in.eop |=> $stable(frame.index))
    else $error("Frame index changed without an end of packet.");

  chk_frame_corrupt:
  assert property (sof_in.eop && sof_in.err |=> frame.corrupt && !frame.good)
    else $error("Corrupt flag not set after a damaged frame.");

  chk_frame_good:
  assert property (sof_in.eop && !sof_in.err |=> frame.good && !frame.corrupt)
    else $error("Good flag not set after a clean frame.");

  chk_frame_clear:
  assert property (sof_in.pid && !sof_in.eop |=> !frame.good && !frame.corrupt)
    else $error("Frame flags not cleared on a new identifier.");

  chk_sof_event:
  assert property (sof_in.pid |=> frame_start_irq ##0 frame.index == $past(frame.index))
    else $error("Start-of-frame event not raised at the identifier.");

  chk_addr_enter:
  assert property (req.wr && sel == SEL_GLB && req.wdata[`UGR_GLB_ADDR_BIT] && !bus_reset_end
    |=> address_state_flag ##1 rd_word[`UGR_GLB_ADDR_BIT] || sel != SEL_GLB)
    else $error("Address state not entered on a write of one.");

  chk_addr_sticky:
  assert property (address_state_flag && !bus_reset_end |=> address_state_flag)
    else $error("Address state left without a reset.");

  chk_conf_write:
  assert property (req.wr && sel == SEL_GLB && !bus_reset_end
    |=> configured_flag == $past(req.wdata[`UGR_GLB_CONF_BIT]))
    else $error("Configured flag does not follow the write.");

  chk_faddr_write:
  assert property (req.wr && sel == SEL_FADDR |=> function_enable_bit ==
    $past(req.wdata[`UGR_FEN_BIT]) && function_address_value ==
    $past(req.wdata[`UGR_FADDR_W-1:0]))
    else $error("Function address register did not take the write.");

  chk_mask_set:
  assert property (req.wr && sel == SEL_IEN && !bus_reset_end
    |=> (irq_mask_view & $past(wr_bits)) == $past(wr_bits))
    else $error("Enable write failed to set mask bits.");

  chk_mask_clear:
  assert property (req.wr && sel == SEL_IDIS && !bus_reset_end
    |=> (irq_mask_view & $past(wr_bits)) == '0)
    else $error("Disable write failed to clear mask bits.");

  chk_mask_idle:
  assert property (!(req.wr && (sel == SEL_IEN || sel == SEL_IDIS)) && !bus_reset_end
    |=> $stable(irq_mask_view))
    else $error("Mask changed without an enable or disable write.");

  chk_mask_fixed:
  assert property (irq_mask_view[`UGR_MASK_FIXED_BIT])
    else $error("Bus reset mask bit reads zero.");

  chk_busres_mask:
  assert property (bus_reset_end |=> irq_mask_view == `UGR_MASK_RST && ep_csr_reset
    ##1 !ep_csr_reset || $past(bus_reset_end))
    else $error("End of bus reset did not restore the mask.");

  chk_irq_out:
  assert property (|(irq_status & irq_mask_view) |=> device_irq)
    else $error("Interrupt output missing for an enabled status bit.");

  chk_irq_quiet:
  assert property (!(|(irq_status & irq_mask_view)) |=> !device_irq)
    else $error("Interrupt output raised with no enabled status bit.");

  chk_addr_busres:
  assert property (bus_reset_end |=> !address_state_flag && !configured_flag)
    else $error("End of bus reset did not return the device to default state.");

  // Main scenarios worth seeing.
  cov_clean_frame: cover property (sof_in.pid ##[1:1000] sof_in.eop && !sof_in.err);
  cov_enumerate: cover property (bus_reset_end ##[1:1000] address_state_flag
    ##[1:1000] configured_flag);
  cov_irq_raise: cover property (!device_irq ##1 device_irq);
  cov_mask_read: cover property (sel == SEL_IMASK && !hreadyout);
endmodule : ugr_top
`default_nettype wire

// ===== src/ugr_regs.svh
`ifndef UGR_REGS_SVH
`define UGR_REGS_SVH
// Register byte offsets within the block's window.
`define UGR_ADDR_W 8
`define UGR_OFF_FRAME 8'h00
`define UGR_OFF_GLB 8'h04
`define UGR_OFF_FADDR 8'h08
`define UGR_OFF_IEN 8'h10
`define UGR_OFF_IDIS 8'h14
`define UGR_OFF_IMASK 8'h18
// Bus encodings.
`define UGR_HTRANS_ACTIVE_BIT 1
`define UGR_HSIZE_WORD 3'h2
// Frame register layout.
`define UGR_FRM_IDX_W 11
`define UGR_FRM_CORRUPT_BIT 16
`define UGR_FRM_GOOD_BIT 17
// Global state register layout.
`define UGR_GLB_ADDR_BIT 0
`define UGR_GLB_CONF_BIT 1
// Function address register layout and reset.
`define UGR_FADDR_W 7
`define UGR_FEN_BIT 8
`define UGR_FADDR_RST 7'h00
`define UGR_FEN_RST 1'h1
// Interrupt mask layout.
`define UGR_MASK_W 14
`define UGR_MASK_RST 14'h1200
`define UGR_MASK_WRITABLE 14'h2B3F
`define UGR_MASK_FIXED 14'h1000
`define UGR_MASK_FIXED_BIT 12
`define UGR_EP_MAX 6
`endif

// ===== src/ugr_pkg.sv
`default_nettype none
`include "ugr_regs.svh"
package ugr_pkg;
  // Start-of-frame events from the serial engine.
  typedef struct packed {
    logic pid;
    logic eop;
    logic err;
    logic [`UGR_FRM_IDX_W-1:0] num;
  } ugr_sof_in_t;
  // Captured frame state.
  typedef struct packed {
    logic [`UGR_FRM_IDX_W-1:0] index;
    logic good;
    logic corrupt;
    logic start_evt;
  } ugr_frame_t;
  // Data-phase request from the bus slave.
  typedef struct packed {
    logic wr;
    logic [`UGR_ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } ugr_bus_req_t;
  typedef struct packed {
    logic dvalid;
    logic dwrite;
    logic rwait;
    logic [`UGR_ADDR_W-1:0] daddr;
    logic [31:0] rdata;
  } ugr_slv_state_t;
  typedef struct packed {
    logic addr_state;
    logic configured;
    logic [`UGR_FADDR_W-1:0] fn_addr;
    logic fn_en;
    logic [`UGR_MASK_W-1:0] mask;
    logic csr_reset;
    logic irq;
  } ugr_core_state_t;
  typedef enum logic [2:0] {SEL_NONE, SEL_FRAME, SEL_GLB, SEL_FADDR, SEL_IEN, SEL_IDIS,
    SEL_IMASK} ugr_sel_t;
endpackage : ugr_pkg
`default_nettype wire

// ===== src/ugr_ahb_slave.sv
`timescale 1ns/10ps
`default_nettype none
`include "ugr_regs.svh"
module ugr_ahb_slave import ugr_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] rd_word,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output var ugr_bus_req_t req
);
  ugr_slv_state_t state_r;
  ugr_slv_state_t state_nxt;
  logic accept;

  // Only whole-word transfers are taken; others complete at once and are ignored.
  assign accept = hsel & htrans[`UGR_HTRANS_ACTIVE_BIT] & hready & (hsize == `UGR_HSIZE_WORD);

  // Reads take one wait state so that read data leaves a flip-flop.
  always_comb begin
    state_nxt = state_r;
    if (state_r.dvalid && state_r.rwait) begin
      state_nxt.rdata = rd_word;
      state_nxt.rwait = 1'b0;
    end else begin
      state_nxt.dvalid = accept;
      state_nxt.dwrite = hwrite;
      state_nxt.daddr = haddr[`UGR_ADDR_W-1:0];
      state_nxt.rwait = accept & ~hwrite;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Write data is taken straight from the data phase.
  assign hreadyout = ~(state_r.dvalid & state_r.rwait);
  assign hresp = 1'b0;
  assign hrdata = state_r.rdata;
  assign req.wr = state_r.dvalid & state_r.dwrite;
  assign req.addr = state_r.daddr;
  assign req.wdata = hwdata;
endmodule : ugr_ahb_slave
`default_nettype wire

// ===== src/ugr_sof_capture.sv
`timescale 1ns/10ps
`default_nettype none
`include "ugr_regs.svh"
module ugr_sof_capture import ugr_pkg::*; (
  input wire logic clk,
  input wire logic rst_b,
  input wire ugr_sof_in_t sof_in,
  output var ugr_frame_t frame
);
  ugr_frame_t state_r;
  ugr_frame_t state_nxt;

  // The end of packet is handled after the identifier, so a set beats a clear.
  always_comb begin
    state_nxt = state_r;
    state_nxt.start_evt = sof_in.pid;
    if (sof_in.pid) begin
      state_nxt.good = 1'b0;
      state_nxt.corrupt = 1'b0;
    end
    if (sof_in.eop) begin
      state_nxt.index = sof_in.num;
      state_nxt.corrupt = sof_in.err;
      state_nxt.good = ~sof_in.err;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign frame = state_r;
endmodule : ugr_sof_capture
`default_nettype wire

// ===== bench/ugr_host_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "ugr_regs.svh"
module ugr_host_model import ugr_pkg::*; (
  input wire logic clk,
  output var ugr_sof_in_t sof_in,
  output logic bus_reset_end
);
  // Lines start quiet; number and error mean nothing outside the end-of-packet beat.
  initial begin
    sof_in = '0;
    bus_reset_end = 1'b0;
  end

  // Token identifier beat; the packet end always follows it, never precedes it.
  task automatic sof_pid();
    sof_in.pid <= 1'b1;
    @(posedge clk);
    sof_in.pid <= 1'b0;
  endtask : sof_pid

  // End of packet with its number and error; afterwards the released lines are inverted,
  // so a design that samples them late sees garbage instead of a lucky match.
  task automatic sof_eop(input logic [`UGR_FRM_IDX_W-1:0] num, input logic err);
    sof_in.eop <= 1'b1;
    sof_in.num <= num;
    sof_in.err <= err;
    @(posedge clk);
    sof_in.eop <= 1'b0;
    sof_in.num <= ~num;
    sof_in.err <= ~err;
  endtask : sof_eop

  // End of a bus reset seen on the wire, one beat.
  task automatic bus_reset();
    bus_reset_end <= 1'b1;
    @(posedge clk);
    bus_reset_end <= 1'b0;
  endtask : bus_reset
endmodule : ugr_host_model
`default_nettype wire

// ===== bench/usb_device_global_regs_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "ugr_regs.svh"
module usb_device_global_regs_test import ugr_pkg::*;;
  logic clk, rst_b, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, q, w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [`UGR_MASK_W-1:0] irq_status, irq_mask_view, exp_mask;
  logic [`UGR_FRM_IDX_W-1:0] num, idx;
  logic [`UGR_FADDR_W-1:0] function_address_value, fa;
  logic frame_start_irq, ep_csr_reset, address_state_flag, configured_flag;
  logic function_enable_bit, device_irq, err;
  logic [2:0] xsize;
  ugr_sof_in_t sof_in;
  logic bus_reset_end;
  int n_mismatch, checked;

  assign hready = hreadyout;

  ugr_top dut_u (.clk(clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sof_in(sof_in),
    .bus_reset_end(bus_reset_end), .irq_status(irq_status),
    .frame_start_irq(frame_start_irq), .ep_csr_reset(ep_csr_reset),
    .address_state_flag(address_state_flag), .configured_flag(configured_flag),
    .function_address_value(function_address_value),
    .function_enable_bit(function_enable_bit), .irq_mask_view(irq_mask_view),
    .device_irq(device_irq));

  ugr_host_model host_u (.clk(clk), .sof_in(sof_in), .bus_reset_end(bus_reset_end));

  // Free-running 40 MHz clock.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare one value; four-state equality so an unknown never matches.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Wait for ready sampled at an edge; the level is taken at the falling edge before it,
  // because the flops behind it only move on rising edges.
  // Only the watchdog ends a wait that never sees ready.
  task automatic wait_rdy(output logic [31:0] d);
    logic r;
    do begin
      @(negedge clk);
      r = hreadyout;
      d = hrdata;
      @(posedge clk);
    end while (r !== 1'b1);
  endtask : wait_rdy

  // One single transfer of size xsize; entered just after a rising edge.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= xsize;
    wait_rdy(q);
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy(q);
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
    chk(hresp, 32'h0);
  endtask : rd_chk

  // Expected frame register word from index and flags.
  function automatic logic [31:0] frm_word(input logic [10:0] i, input logic g, input logic c);
    return {14'h0, g, c, 5'h0, i};
  endfunction : frm_word

  task automatic results();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  // Cuts a hang short; the whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    rst_b = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    xsize = `UGR_HSIZE_WORD;
    hwdata = 32'h0;
    irq_status = '0;
    n_mismatch = 0;
    checked = 0;
    void'($urandom(81));
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    // Reset values, plus the reserved hole that reads zero.
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h0);
    rd_chk(8'h08, 32'h100);
    rd_chk(8'h18, 32'h1200);
    rd_chk(8'h0C, 32'h0);
    $display("test reset done");
    // Frames: clean and corrupt alternate, flags are read between identifier and end.
    idx = '0;
    for (int i = 0; i < 4; i++) begin
      num = 11'($urandom);
      err = i[0];
      host_u.sof_pid();
      @(negedge clk);
      chk(frame_start_irq, 1);
      @(posedge clk);
      rd_chk(8'h00, frm_word(idx, 1'b0, 1'b0));
      host_u.sof_eop(num, err);
      idx = num;
      rd_chk(8'h00, frm_word(num, ~err, err));
      wr(8'h00, 32'hFFFFFFFF);
      rd_chk(8'h00, frm_word(num, ~err, err));
    end
    $display("test frame done");
    // Device state: a bus reset from the host, the address, then address state, then
    // configuration.
    host_u.bus_reset();
    fa = 7'($urandom);
    wr(8'h08, {23'h0, 1'b1, 1'b0, fa});
    @(negedge clk);
    chk(function_address_value, fa);
    @(posedge clk);
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h1);
    wr(8'h04, 32'h0);
    rd_chk(8'h04, 32'h1);
    wr(8'h04, 32'h3);
    rd_chk(8'h04, 32'h3);
    chk(configured_flag, 1);
    // A byte-sized write is not taken, so the configured state must survive it.
    xsize = 3'h0;
    wr(8'h04, 32'h1);
    xsize = `UGR_HSIZE_WORD;
    rd_chk(8'h04, 32'h3);
    wr(8'h04, 32'h1);
    rd_chk(8'h04, 32'h1);
    wr(8'h08, {25'h0, fa});
    rd_chk(8'h08, {25'h0, fa});
    chk(function_enable_bit, 0);
    wr(8'h08, {23'h0, 1'b1, 1'b0, fa});
    $display("test state done");
    // Mask: everything on and off, then a random mix of set and clear writes.
    wr(8'h10, 32'hFFFFFFFF);
    rd_chk(8'h18, {18'h0, `UGR_MASK_WRITABLE | `UGR_MASK_FIXED});
    wr(8'h14, 32'hFFFFFFFF);
    rd_chk(8'h18, 32'h1000);
    exp_mask = '0;
    for (int i = 0; i < 10; i++) begin
      w = $urandom;
      if (i[0]) begin
        wr(8'h14, w);
        exp_mask = exp_mask & ~w[13:0];
      end else begin
        wr(8'h10, w);
        exp_mask = exp_mask | (w[13:0] & `UGR_MASK_WRITABLE);
      end
      rd_chk(8'h18, {18'h0, exp_mask | `UGR_MASK_FIXED});
      chk(irq_mask_view, {18'h0, exp_mask | `UGR_MASK_FIXED});
    end
    $display("test mask done");
    // Interrupt output follows status gated by the mask.
    for (int i = 0; i < 8; i++) begin
      irq_status <= (i == 0) ? 14'h1000 : (i == 1) ? ~(exp_mask | `UGR_MASK_FIXED) :
        14'($urandom);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk(device_irq, |(irq_status & (exp_mask | `UGR_MASK_FIXED)));
      @(posedge clk);
    end
    $display("test irq done");
    // End of bus reset restores the mask and pulses the endpoint reset.
    // Status drops first so that no stale source meets the second reset below.
    irq_status <= '0;
    host_u.bus_reset();
    @(negedge clk);
    chk(ep_csr_reset, 1);
    chk(address_state_flag, 0);
    @(posedge clk);
    rd_chk(8'h18, 32'h1200);
    rd_chk(8'h08, {23'h0, 1'b1, 1'b0, fa});
    $display("test bus reset done");
    // A second hardware reset in mid-run must bring the registers back to power-up values.
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd_chk(8'h08, 32'h100);
    rd_chk(8'h04, 32'h0);
    $display("test second reset done");
    results();
  end
endmodule : usb_device_global_regs_test
`default_nettype wire
